//--- rtl/psr_sensor_dev.sv
// sensor end: measurement cycle, status encoding and read-only link slave
`include "psr_defines.svh"

module psr_sensor_dev #(
	parameter int unsigned UPDATE_CYCLES = `PSR_UPDATE_NS / `PSR_MCLK_NS
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic linkClk,
	psr_link_if.dev link,
	input wire logic [13:0] pressureIn,
	input wire logic [10:0] tempIn,
	input wire logic [`PSR_FAULT_W-1:0] faultIn,
	input wire logic cmdMode,
	input wire logic sleepMode,
	input wire logic addrLock,
	output logic [1:0] statusOut,
	output logic measBusy
);
	logic [31:0] measCnt_reg;
	logic measActive_reg;
	logic measDone;
	logic reqPend_reg;
	logic [13:0] pres_reg;
	logic [10:0] temp_reg;
	logic fault_reg;
	logic stale_reg;
	psr_pkg::psr_status_t statusNext;
	psr_pkg::psr_status_t status_reg;
	logic reqS1;
	logic reqS2;
	logic reqSeen_reg;
	logic snapEvt;
	logic ackTog_reg;
	psr_pkg::psr_packet_t snap_reg;

	logic lrstS1;
	logic lrstS2;
	logic sclS1;
	logic sclS2;
	logic sclP;
	logic sdaS1;
	logic sdaS2;
	logic sdaP;
	logic akS1;
	logic akS2;
	logic lockS1;
	logic lockS2;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic addrHit;
	logic snapReady;
	psr_pkg::psr_link_state_t lstate_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [2:0] byteIdx_reg;
	logic [7:0] nextByte;
	logic [7:0] firstByte;
	logic poison_reg;
	logic sawRise_reg;
	logic sdaOe_reg;
	logic sdaOut_reg;
	logic snapTog_reg;

	function automatic logic [7:0] pktByte(input logic [2:0] idx, input psr_pkg::psr_packet_t p);
		case (idx)
			3'h0: pktByte = {p.status, p.pres[13:8]};
			3'h1: pktByte = p.pres[7:0];
			3'h2: pktByte = p.temp[10:3];
			3'h3: pktByte = {p.temp[2:0], `PSR_TEMP_PAD};
			default: pktByte = `PSR_BYTE_PAD;
		endcase
	endfunction : pktByte

	// fetch requests arrive from the link domain as a toggle
	always_ff @(posedge mclk) begin
		reqS1 <= snapTog_reg;
		reqS2 <= reqS1;
	end
	assign snapEvt = reqS2 ^ reqSeen_reg;

	// free-running in update mode; sleep mode waits for a request
	// a request mid-cycle is kept, so its own full cycle still follows
	always_ff @(posedge mclk) begin
		if (srst) begin
			measCnt_reg <= 32'h0;
			measActive_reg <= 1'b1;
			reqPend_reg <= 1'b0;
		end else if (measActive_reg) begin
			if (measCnt_reg == UPDATE_CYCLES - 1) begin
				measCnt_reg <= 32'h0;
				reqPend_reg <= 1'b0;
				measActive_reg <= !sleepMode || snapEvt || reqPend_reg;
			end else begin
				measCnt_reg <= measCnt_reg + 32'h1;
				reqPend_reg <= reqPend_reg || snapEvt;
			end
		end else if (snapEvt || !sleepMode) begin
			measActive_reg <= 1'b1;
		end
	end
	assign measDone = measActive_reg && (measCnt_reg == UPDATE_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (srst) begin
			pres_reg <= 14'h0000;
			temp_reg <= 11'h000;
		end else if (measDone) begin
			temp_reg <= tempIn;
			if (pressureIn < `PSR_PRES_MIN) begin
				pres_reg <= `PSR_PRES_MIN;
			end else if (pressureIn > `PSR_PRES_MAX) begin
				pres_reg <= `PSR_PRES_MAX;
			end else begin
				pres_reg <= pressureIn;
			end
		end
	end

	// only reset clears it; a lasting cause sets it again next cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			fault_reg <= 1'b0;
		end else if (measDone && (|faultIn)) begin
			fault_reg <= 1'b1;
		end
	end

	// a fetch in the same cycle as completion leaves it stale
	always_ff @(posedge mclk) begin
		if (srst) begin
			stale_reg <= 1'b1;
		end else if (snapEvt) begin
			stale_reg <= 1'b1;
		end else if (measDone) begin
			stale_reg <= 1'b0;
		end
	end

	always_comb begin
		if (fault_reg) begin
			statusNext = psr_pkg::ST_FAULT;
		end else if (cmdMode) begin
			statusNext = psr_pkg::ST_CMD;
		end else if (stale_reg) begin
			statusNext = psr_pkg::ST_STALE;
		end else begin
			statusNext = psr_pkg::ST_GOOD;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_reg <= psr_pkg::ST_STALE;
		end else begin
			status_reg <= statusNext;
		end
	end
	assign statusOut = status_reg;
	assign measBusy = measActive_reg;

	// snapshot stays still until the link asks again, so it may be read across
	always_ff @(posedge mclk) begin
		if (srst) begin
			reqSeen_reg <= 1'b0;
			ackTog_reg <= 1'b0;
			snap_reg <= '0;
		end else if (snapEvt) begin
			reqSeen_reg <= reqS2;
			ackTog_reg <= !ackTog_reg;
			snap_reg <= '{status: statusNext, pres: pres_reg, temp: temp_reg};
		end
	end

	// link domain: reset, pins and handshake answer pass two flops each
	always_ff @(posedge linkClk) begin
		lrstS1 <= srst;
		lrstS2 <= lrstS1;
		sclS1 <= link.scl;
		sclS2 <= sclS1;
		sclP <= sclS2;
		sdaS1 <= link.sda;
		sdaS2 <= sdaS1;
		sdaP <= sdaS2;
		akS1 <= ackTog_reg;
		akS2 <= akS1;
		lockS1 <= addrLock;
		lockS2 <= lockS1;
	end

	assign sclRise = sclS2 && !sclP;
	assign sclFall = !sclS2 && sclP;
	assign startCond = sclS2 && sclP && sdaP && !sdaS2;
	assign stopCond = sclS2 && sclP && !sdaP && sdaS2;
	assign addrHit = (shift_reg[6:0] == `PSR_SLAVE_ADDR);
	assign snapReady = (akS2 == snapTog_reg);
	assign nextByte = pktByte(byteIdx_reg + 3'h1, snap_reg);
	assign firstByte = pktByte(3'h0, snap_reg);

	always_ff @(posedge linkClk) begin
		if (lrstS2) begin
			sdaOut_reg <= 1'b0;
		end
	end

	always_ff @(posedge linkClk) begin
		if (lrstS2) begin
			lstate_reg <= psr_pkg::L_IDLE;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			byteIdx_reg <= 3'h0;
			poison_reg <= 1'b0;
			sawRise_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			snapTog_reg <= 1'b0;
		end else if (startCond) begin
			sdaOe_reg <= 1'b0;
			sawRise_reg <= 1'b0;
			bitCnt_reg <= 4'h0;
			if (poison_reg) begin
				poison_reg <= 1'b0;
				lstate_reg <= psr_pkg::L_IDLE;
			end else if (lstate_reg != psr_pkg::L_IDLE) begin
				poison_reg <= 1'b1;
				lstate_reg <= psr_pkg::L_IDLE;
			end else begin
				lstate_reg <= psr_pkg::L_ADDR;
			end
		end else if (stopCond) begin
			sdaOe_reg <= 1'b0;
			if (lstate_reg == psr_pkg::L_ADDR && !sawRise_reg) begin
				poison_reg <= 1'b1;
			end
			lstate_reg <= psr_pkg::L_IDLE;
		end else begin
			case (lstate_reg)
				psr_pkg::L_ADDR: begin
					if (sclRise) begin
						shift_reg <= {shift_reg[6:0], sdaS2};
						bitCnt_reg <= bitCnt_reg + 4'h1;
						sawRise_reg <= 1'b1;
						if (bitCnt_reg == `PSR_LAST_BIT) begin
							if (sdaS2 && (addrHit || !lockS2)) begin
								lstate_reg <= psr_pkg::L_AACK;
							end else begin
								lstate_reg <= psr_pkg::L_WAIT;
							end
						end
					end
				end
				psr_pkg::L_AACK: begin
					if (sclFall) begin
						if (!sdaOe_reg) begin
							sdaOe_reg <= 1'b1;
							snapTog_reg <= !snapTog_reg;
						end else if (snapReady) begin
							byteIdx_reg <= 3'h0;
							shift_reg <= firstByte;
							sdaOe_reg <= !firstByte[7];
							bitCnt_reg <= 4'h0;
							lstate_reg <= psr_pkg::L_SEND;
						end else begin
							sdaOe_reg <= 1'b0;
							lstate_reg <= psr_pkg::L_WAIT;
						end
					end
				end
				psr_pkg::L_SEND: begin
					if (sclFall) begin
						if (bitCnt_reg == `PSR_LAST_BIT) begin
							sdaOe_reg <= 1'b0;
							lstate_reg <= psr_pkg::L_MACK;
						end else begin
							sdaOe_reg <= !shift_reg[6];
							shift_reg <= {shift_reg[6:0], 1'b0};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end
					end
				end
				psr_pkg::L_MACK: begin
					if (sclRise && sdaS2) begin
						lstate_reg <= psr_pkg::L_WAIT;
					end else if (sclFall) begin
						byteIdx_reg <= byteIdx_reg + 3'h1;
						shift_reg <= nextByte;
						sdaOe_reg <= !nextByte[7];
						bitCnt_reg <= 4'h0;
						lstate_reg <= psr_pkg::L_SEND;
					end
				end
				psr_pkg::L_IDLE, psr_pkg::L_WAIT: begin
					sdaOe_reg <= 1'b0;
				end
				default: begin
					lstate_reg <= psr_pkg::L_IDLE;
				end
			endcase
		end
	end

	assign link.devSdaOe = sdaOe_reg;
	assign link.devSdaOut = sdaOut_reg;
endmodule : psr_sensor_dev

//--- pkg/psr_defines.svh
// constants for the pressure sensor readout link: address, timing and packet figures
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH
`define PSR_SLAVE_ADDR 7'h28
`define PSR_MCLK_NS 5
`define PSR_UPDATE_NS 2000000
`define PSR_SCL_PERIOD_NS 2500
`define PSR_BUS_FREE_NS 2000
`define PSR_QUARTER_CYC (`PSR_SCL_PERIOD_NS / `PSR_MCLK_NS / 4)
`define PSR_FREE_CYC ((`PSR_BUS_FREE_NS + `PSR_MCLK_NS - 1) / `PSR_MCLK_NS)
`define PSR_PRES_MIN 14'h0666
`define PSR_PRES_MAX 14'h3999
`define PSR_TEMP_PAD 5'h00
`define PSR_BYTE_PAD 8'h00
`define PSR_LAST_BIT 4'h7
`define PSR_ACK_SLOT 4'h8
`define PSR_FAULT_W 4
`endif

//--- pkg/psr_pkg.sv
// types shared by both ends of the pressure sensor readout link
package psr_pkg;
	typedef enum logic [1:0] {
		ST_GOOD = 2'h0,
		ST_CMD = 2'h1,
		ST_STALE = 2'h2,
		ST_FAULT = 2'h3
	} psr_status_t;

	typedef struct packed {
		psr_status_t status;
		logic [13:0] pres;
		logic [10:0] temp;
	} psr_packet_t;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_ADDR = 3'h1,
		L_AACK = 3'h2,
		L_SEND = 3'h3,
		L_MACK = 3'h4,
		L_WAIT = 3'h5
	} psr_link_state_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_START = 3'h1,
		M_REC = 3'h2,
		M_BIT = 3'h3,
		M_STOP = 3'h4,
		M_FREE = 3'h5
	} psr_mst_state_t;

	typedef enum logic [2:0] {
		REQ_MEASUREMENT_REQUEST = 3'h0,
		REQ_FETCH_TWO_BYTES = 3'h2,
		REQ_FETCH_THREE_BYTES = 3'h3,
		REQ_FETCH_FOUR_BYTES = 3'h4
	} psr_req_t;
endpackage : psr_pkg

//--- pkg/psr_link_if.sv
// two-wire link between the bus master and the sensor; sda is open drain
interface psr_link_if;
	logic scl;
	logic sda;
	logic mstSdaOut;
	logic mstSdaOe;
	logic devSdaOut;
	logic devSdaOe;

	// wired-and: any enabled driver holding low pulls the line low
	assign sda = !((mstSdaOe && !mstSdaOut) || (devSdaOe && !devSdaOut));

	modport dev(input scl, input sda, output devSdaOut, output devSdaOe);
	modport mst(output scl, input sda, output mstSdaOut, output mstSdaOe);
endinterface : psr_link_if

//--- rtl/psr_bus_master.sv
// master end: generates scl by division and runs one read transaction per command
`include "psr_defines.svh"

module psr_bus_master (
	input wire logic mclk,
	input wire logic srst,
	psr_link_if.mst link,
	input wire logic cmdValid,
	input wire psr_pkg::psr_req_t cmdLen,
	input wire logic [6:0] cmdAddr,
	input wire logic cmdRecover,
	output logic cmdReady,
	output logic done,
	output logic [31:0] rxData,
	output logic addrNack
);
	psr_pkg::psr_mst_state_t mstate_reg;
	logic [7:0] qCnt_reg;
	logic [1:0] qPh_reg;
	logic tick;
	logic [8:0] freeCnt_reg;
	logic [3:0] slot_reg;
	logic [2:0] byte_reg;
	logic [2:0] len_reg;
	logic [8:0] addrSh_reg;
	logic recPending_reg;
	logic bitVal;
	logic sdaS1;
	logic sdaS2;
	logic scl_reg;
	logic sdaOe_reg;
	logic sdaOut_reg;
	logic ready_reg;
	logic done_reg;
	logic [31:0] rx_reg;
	logic nack_reg;

	always_ff @(posedge mclk) begin
		sdaS1 <= link.sda;
		sdaS2 <= sdaS1;
	end

	always_ff @(posedge mclk) begin
		if (srst || mstate_reg == psr_pkg::M_IDLE || tick) begin
			qCnt_reg <= 8'h00;
		end else begin
			qCnt_reg <= qCnt_reg + 8'h01;
		end
	end
	assign tick = (qCnt_reg == 8'(`PSR_QUARTER_CYC - 1));

	// address bits then the read bit; data slots released; ack slot per byte
	always_comb begin
		if (byte_reg == 3'h0) begin
			bitVal = addrSh_reg[8];
		end else if (slot_reg != `PSR_ACK_SLOT) begin
			bitVal = 1'b1;
		end else begin
			bitVal = (byte_reg == len_reg);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			mstate_reg <= psr_pkg::M_IDLE;
			qPh_reg <= 2'h0;
			freeCnt_reg <= 9'h000;
			slot_reg <= 4'h0;
			byte_reg <= 3'h0;
			len_reg <= 3'h0;
			addrSh_reg <= 9'h000;
			recPending_reg <= 1'b0;
			scl_reg <= 1'b1;
			sdaOe_reg <= 1'b0;
			sdaOut_reg <= 1'b0;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			rx_reg <= 32'h0;
			nack_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (tick) begin
				qPh_reg <= qPh_reg + 2'h1;
			end
			case (mstate_reg)
				psr_pkg::M_IDLE: begin
					qPh_reg <= 2'h0;
					if (cmdValid) begin
						ready_reg <= 1'b0;
						len_reg <= cmdLen;
						addrSh_reg <= {cmdAddr, 2'h3};
						recPending_reg <= cmdRecover;
						rx_reg <= 32'h0;
						nack_reg <= 1'b0;
						slot_reg <= 4'h0;
						byte_reg <= 3'h0;
						mstate_reg <= psr_pkg::M_START;
					end
				end
				psr_pkg::M_START: begin
					if (tick && qPh_reg == 2'h0) begin
						sdaOe_reg <= 1'b1;
					end else if (tick) begin
						qPh_reg <= 2'h0;
						mstate_reg <= recPending_reg ? psr_pkg::M_REC : psr_pkg::M_BIT;
					end
				end
				// one clock with sda high, then a fresh start, clears a corrupted slave
				psr_pkg::M_REC: begin
					if (tick) begin
						case (qPh_reg)
							2'h0: scl_reg <= 1'b0;
							2'h1: sdaOe_reg <= 1'b0;
							2'h2: scl_reg <= 1'b1;
							default: begin
								recPending_reg <= 1'b0;
								mstate_reg <= psr_pkg::M_START;
							end
						endcase
					end
				end
				psr_pkg::M_BIT: begin
					if (tick) begin
						case (qPh_reg)
							2'h0: scl_reg <= 1'b0;
							2'h1: sdaOe_reg <= !bitVal;
							2'h2: scl_reg <= 1'b1;
							default: begin
								if (byte_reg == 3'h0) begin
									addrSh_reg <= {addrSh_reg[7:0], 1'b1};
								end
								if (slot_reg != `PSR_ACK_SLOT) begin
									slot_reg <= slot_reg + 4'h1;
									if (byte_reg != 3'h0) begin
										rx_reg <= {rx_reg[30:0], sdaS2};
									end
								end else begin
									slot_reg <= 4'h0;
									if (byte_reg == 3'h0 && (sdaS2 || len_reg == 3'h0)) begin
										nack_reg <= sdaS2;
										mstate_reg <= psr_pkg::M_STOP;
									end else if (byte_reg == len_reg) begin
										if (len_reg == 3'(psr_pkg::REQ_FETCH_FOUR_BYTES)) begin
											rx_reg[4:0] <= `PSR_TEMP_PAD;
										end
										mstate_reg <= psr_pkg::M_STOP;
									end else begin
										byte_reg <= byte_reg + 3'h1;
									end
								end
							end
						endcase
					end
				end
				psr_pkg::M_STOP: begin
					if (tick) begin
						case (qPh_reg)
							2'h0: scl_reg <= 1'b0;
							2'h1: sdaOe_reg <= 1'b1;
							2'h2: scl_reg <= 1'b1;
							default: begin
								sdaOe_reg <= 1'b0;
								freeCnt_reg <= 9'h000;
								mstate_reg <= psr_pkg::M_FREE;
							end
						endcase
					end
				end
				psr_pkg::M_FREE: begin
					if (freeCnt_reg == 9'(`PSR_FREE_CYC - 1)) begin
						done_reg <= 1'b1;
						ready_reg <= 1'b1;
						mstate_reg <= psr_pkg::M_IDLE;
					end else begin
						freeCnt_reg <= freeCnt_reg + 9'h001;
					end
				end
				default: mstate_reg <= psr_pkg::M_IDLE;
			endcase
		end
	end

	assign link.scl = scl_reg;
	assign link.mstSdaOe = sdaOe_reg;
	assign link.mstSdaOut = sdaOut_reg;
	assign cmdReady = ready_reg;
	assign done = done_reg;
	assign rxData = rx_reg;
	assign addrNack = nack_reg;
endmodule : psr_bus_master

//--- verif/psr_link_assertions.sv
// concurrent checks on the two-wire link between bus master and sensor
module psr_link_assertions (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda,
	input wire logic mstSdaOut,
	input wire logic mstSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe
);
	localparam int MIN_HALF = 120;
	localparam int BUS_FREE = 400;
	logic sclDly_reg;
	logic sdaDly_reg;
	logic head_reg;
	logic [9:0] levelCnt_reg;
	logic [9:0] freeCnt_reg;
	logic startSeen;
	logic stopSeen;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// edges from a registered copy, so no sampled-value call sits in plain logic
	assign startSeen = scl && sclDly_reg && sdaDly_reg && !sda;
	assign stopSeen = scl && sclDly_reg && !sdaDly_reg && sda;

	always_ff @(posedge mclk) begin
		sclDly_reg <= scl;
		sdaDly_reg <= sda;
	end

	always_ff @(posedge mclk) begin
		if (srst || startSeen) begin
			head_reg <= !srst;
		end else if (scl && !sclDly_reg) begin
			head_reg <= 1'b0;
		end
	end

	// saturating: a long idle level must not wrap below the minimum
	always_ff @(posedge mclk) begin
		if (srst) begin
			levelCnt_reg <= 10'h3FF;
		end else if (scl != sclDly_reg) begin
			levelCnt_reg <= 10'h001;
		end else if (levelCnt_reg != 10'h3FF) begin
			levelCnt_reg <= levelCnt_reg + 10'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			freeCnt_reg <= 10'h3FF;
		end else if (stopSeen) begin
			freeCnt_reg <= 10'h000;
		end else if (freeCnt_reg != 10'h3FF) begin
			freeCnt_reg <= freeCnt_reg + 10'h001;
		end
	end

	a_wire_drive_low: assert property (!mstSdaOut && !devSdaOut)
		else $error("sda driver data not held low");
	a_dev_no_restart: assert property (scl && $past(scl) && $fell(sda) |-> !devSdaOe)
		else $error("sensor made a start edge");
	a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
		else $error("sensor changed sda while scl high");
	a_stop_release: assert property (stopSeen |-> !devSdaOe ##1 !devSdaOe)
		else $error("sensor still drives after stop");
	a_head_no_fall: assert property (head_reg |-> !$fell(sda))
		else $error("falling sda before first scl rise");
	a_start_hold: assert property (startSeen |=> (scl && !sda)[*8])
		else $error("start not held");
	a_scl_width: assert property (scl != sclDly_reg |-> levelCnt_reg >= MIN_HALF)
		else $error("scl level too short");
	a_bus_free: assert property (startSeen |-> freeCnt_reg >= BUS_FREE)
		else $error("bus free time too short");
	a_reset_idle: assert property ($fell(srst) |-> scl && !mstSdaOe && !devSdaOe)
		else $error("link not idle after reset");
endmodule : psr_link_assertions

//--- verif/tb.sv
// self-checking bench: master and sensor joined over the link
`define CHK(what, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("Error %s expected %0h seen %0h", what, exp, got); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int UPD = 20000;
	logic mclk;
	logic srst;
	logic linkClk;
	logic [13:0] pressureIn;
	logic [10:0] tempIn;
	logic [3:0] faultIn;
	logic cmdMode;
	logic sleepMode;
	logic addrLock;
	logic [1:0] statusOut;
	logic measBusy;
	logic cmdValid;
	psr_pkg::psr_req_t cmdLen;
	logic [6:0] cmdAddr;
	logic cmdRecover;
	logic cmdReady;
	logic done;
	logic [31:0] rxData;
	logic addrNack;
	int errors;
	int comparisons;

	psr_link_if link();

	psr_sensor_dev #(.UPDATE_CYCLES(UPD)) u_psr_sensor_dev (.mclk(mclk), .srst(srst),
		.linkClk(linkClk), .link(link), .pressureIn(pressureIn), .tempIn(tempIn),
		.faultIn(faultIn), .cmdMode(cmdMode), .sleepMode(sleepMode), .addrLock(addrLock),
		.statusOut(statusOut), .measBusy(measBusy));

	psr_bus_master u_psr_bus_master (.mclk(mclk), .srst(srst), .link(link),
		.cmdValid(cmdValid), .cmdLen(cmdLen), .cmdAddr(cmdAddr), .cmdRecover(cmdRecover),
		.cmdReady(cmdReady), .done(done), .rxData(rxData), .addrNack(addrNack));

	psr_link_assertions u_psr_link_assertions (.mclk(mclk), .srst(srst), .scl(link.scl),
		.sda(link.sda), .mstSdaOut(link.mstSdaOut), .mstSdaOe(link.mstSdaOe),
		.devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe));

	always #2.5 mclk = ~mclk;
	always #80 linkClk = ~linkClk;

	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// reset spans several link clocks so the synchroniser sees it
	task automatic doReset();
		srst <= 1'b1;
		repeat (10) @(posedge linkClk);
		@(posedge mclk);
		srst <= 1'b0;
	endtask : doReset

	task automatic run(input psr_pkg::psr_req_t len, input logic [6:0] addr);
		int n;
		n = 0;
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmdLen <= len;
		cmdAddr <= addr;
		@(posedge mclk);
		cmdValid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (done !== 1'b1 && n < 40000);
		`CHK("done", 1'b1, done)
	endtask : run

	task automatic waitStatus(input psr_pkg::psr_status_t s, input int limit);
		int n;
		n = 0;
		while (statusOut !== s && n < limit) begin
			@(posedge mclk);
			n++;
		end
		`CHK("statusOut", s, statusOut)
	endtask : waitStatus

	task automatic waitBusy(input logic b, input int limit);
		int n;
		n = 0;
		while (measBusy !== b && n < limit) begin
			@(posedge mclk);
			n++;
		end
		`CHK("measBusy", b, measBusy)
	endtask : waitBusy

	initial begin
		mclk = 1'b0;
		linkClk = 1'b0;
		srst = 1'b1;
		pressureIn = 14'h0100;
		tempIn = 11'h5A3;
		faultIn = 4'h0;
		cmdMode = 1'b0;
		sleepMode = 1'b0;
		addrLock = 1'b1;
		cmdValid = 1'b0;
		cmdLen = psr_pkg::REQ_FETCH_TWO_BYTES;
		cmdAddr = 7'h28;
		cmdRecover = 1'b0;
		errors = 0;
		comparisons = 0;
		doReset();
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("addrNack", 1'b0, addrNack)
		`CHK("early status", 2'h2, rxData[15:14])
		$display("test early fetch done");
		waitStatus(psr_pkg::ST_GOOD, UPD);
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("fresh packet", {2'h0, 14'h0666}, rxData[15:0])
		pressureIn <= 14'h3FFF;
		// second fetch lands before the next cycle completes
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("stale packet", {2'h2, 14'h0666}, rxData[15:0])
		run(psr_pkg::REQ_FETCH_FOUR_BYTES, 7'h28);
		`CHK("four bytes", {2'h0, 14'h3999, 11'h5A3, 5'h00}, rxData)
		$display("test packet layout done");
		run(psr_pkg::REQ_FETCH_THREE_BYTES, 7'h29);
		`CHK("locked nack", 1'b1, addrNack)
		addrLock <= 1'b0;
		run(psr_pkg::REQ_FETCH_THREE_BYTES, 7'h29);
		`CHK("unlocked ack", 1'b0, addrNack)
		`CHK("temp byte", 8'hB4, rxData[7:0])
		$display("test address lock done");
		// an extra start on an idle slave is itself a restart, so it poisons once
		cmdRecover <= 1'b1;
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("restart nack", 1'b1, addrNack)
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("extra start ack", 1'b0, addrNack)
		cmdRecover <= 1'b0;
		$display("test restart recovery done");
		cmdMode <= 1'b1;
		waitStatus(psr_pkg::ST_CMD, UPD);
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("command code", 2'h1, rxData[15:14])
		cmdMode <= 1'b0;
		sleepMode <= 1'b1;
		waitBusy(1'b0, 2 * UPD + 10);
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("sleep fetch", 2'h0, rxData[15:14])
		`CHK("fetch wakes", 1'b1, measBusy)
		// still stale here, so byte0 bit7 is released and the stop is seen
		run(psr_pkg::REQ_MEASUREMENT_REQUEST, 7'h28);
		`CHK("request ack", 1'b0, addrNack)
		waitStatus(psr_pkg::ST_GOOD, UPD);
		`CHK("request cycle", 1'b1, measBusy)
		waitBusy(1'b0, UPD + 10);
		sleepMode <= 1'b0;
		$display("test sleep mode done");
		faultIn <= 4'h4;
		waitStatus(psr_pkg::ST_FAULT, 2 * UPD + 100);
		faultIn <= 4'h0;
		run(psr_pkg::REQ_FETCH_TWO_BYTES, 7'h28);
		`CHK("fault code", 2'h3, rxData[15:14])
		// cause removed; a full span holds at least one completed cycle
		repeat (UPD) @(posedge mclk);
		`CHK("fault sticky", psr_pkg::ST_FAULT, statusOut)
		doReset();
		@(posedge mclk);
		@(posedge mclk);
		`CHK("status after reset", psr_pkg::ST_STALE, statusOut)
		`CHK("busy after reset", 1'b1, measBusy)
		$display("test status codes done");
		stop_test();
	end

	initial begin
		repeat (400000) @(posedge mclk);
		errors++;
		stop_test();
	end
endmodule : tb
